// ==== rtl/fcb_pkg.sv ====
// Constants and carrier types for the channel B upper-tap coefficient bank.
// Assumes a 16-bit register port with 12-bit word addresses.
package fcb_pkg;

  localparam int ADDR_W   = 12;
  localparam int DATA_W   = 16;
  localparam int COEFF_W  = 12;
  localparam int CENTER_W = 18;
  localparam int NUM_TAPS = 9;
  localparam int CTR_IDX  = 4;
  localparam int SUM_GROW = 4;

  localparam logic [ADDR_W-1:0] TAP6_OFS = 12'h453;
  localparam logic [ADDR_W-1:0] TAP7_OFS = 12'h455;
  localparam logic [ADDR_W-1:0] TAP8_OFS = 12'h457;
  localparam logic [ADDR_W-1:0] TAP9_OFS = 12'h459;

  localparam int COEFF_LSB = 0;
  localparam int COEFF_MSB = 11;
  localparam int RESV_LSB  = 12;
  localparam int RESV_MSB  = 15;

  localparam logic [DATA_W-1:0] TAP_RST   = 16'h0000;
  localparam logic [DATA_W-1:0] RD_UNMAP  = 16'h0000;
  localparam logic [1:0]        SYNC_RST  = 2'h0;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } fcb_reg_req_t;

endpackage : fcb_pkg

// ==== rtl/fcb_upper_taps.sv ====
// Channel B equalizer: upper tap coefficient registers and the nine-tap filter.
// Assumes register strobes and samples are synchronous to clk_sys; taps one to
// five arrive as static inputs from the neighbouring coefficient bank.
`timescale 1ns/100ps

module fcb_upper_taps #(
  parameter int SAMPLE_W = 12
) (
  input  wire logic                          clk_sys,
  input  wire logic                          nrst,
  input  wire fcb_pkg::fcb_reg_req_t         reg_req,
  output logic [fcb_pkg::DATA_W-1:0]         reg_rdata,
  input  wire logic                          dual_mode,
  input  wire logic                          samp_valid,
  input  wire logic signed [SAMPLE_W-1:0]    samp_in,
  input  wire logic [fcb_pkg::COEFF_W-1:0]   chan_b_tap1_value,
  input  wire logic [fcb_pkg::COEFF_W-1:0]   chan_b_tap2_value,
  input  wire logic [fcb_pkg::COEFF_W-1:0]   chan_b_tap3_value,
  input  wire logic [fcb_pkg::COEFF_W-1:0]   chan_b_tap4_value,
  input  wire logic [fcb_pkg::CENTER_W-1:0]  chan_b_center_tap_value,
  output logic signed [SAMPLE_W+fcb_pkg::CENTER_W+fcb_pkg::SUM_GROW-1:0] filt_out,
  output logic                               filt_valid
);

  localparam int PROD_W = SAMPLE_W + fcb_pkg::CENTER_W;
  localparam int ACC_W  = PROD_W + fcb_pkg::SUM_GROW;
  localparam int EXT_W  = fcb_pkg::CENTER_W - fcb_pkg::COEFF_W;

  generate
    if (SAMPLE_W < 2 || SAMPLE_W > 16) begin : g_bad_width
      $error("SAMPLE_W must lie between 2 and 16");
    end
  endgenerate

  // Reset release through two flops
  logic [1:0] rst_sync_reg;
  logic       rst_n;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rst_sync_reg <= fcb_pkg::SYNC_RST;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_reg[1];

  // Address decode
  logic hit6;
  logic hit7;
  logic hit8;
  logic hit9;
  logic hit_any;
  logic wr6;
  logic wr7;
  logic wr8;
  logic wr9;

  assign hit6    = reg_req.addr == fcb_pkg::TAP6_OFS;
  assign hit7    = reg_req.addr == fcb_pkg::TAP7_OFS;
  assign hit8    = reg_req.addr == fcb_pkg::TAP8_OFS;
  assign hit9    = reg_req.addr == fcb_pkg::TAP9_OFS;
  assign hit_any = hit6 | hit7 | hit8 | hit9;
  assign wr6     = reg_req.wr & hit6;
  assign wr7     = reg_req.wr & hit7;
  assign wr8     = reg_req.wr & hit8;
  assign wr9     = reg_req.wr & hit9;

  // Coefficient registers; reserved nibble is stored as written
  logic [fcb_pkg::DATA_W-1:0] chan_b_fir_tap6_coeff_reg;
  logic [fcb_pkg::DATA_W-1:0] chan_b_fir_tap7_coeff_reg;
  logic [fcb_pkg::DATA_W-1:0] chan_b_fir_tap8_coeff_reg;
  logic [fcb_pkg::DATA_W-1:0] chan_b_fir_tap9_coeff_reg;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      chan_b_fir_tap6_coeff_reg <= fcb_pkg::TAP_RST;
    end else if (wr6) begin
      chan_b_fir_tap6_coeff_reg <= reg_req.wdata;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      chan_b_fir_tap7_coeff_reg <= fcb_pkg::TAP_RST;
    end else if (wr7) begin
      chan_b_fir_tap7_coeff_reg <= reg_req.wdata;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      chan_b_fir_tap8_coeff_reg <= fcb_pkg::TAP_RST;
    end else if (wr8) begin
      chan_b_fir_tap8_coeff_reg <= reg_req.wdata;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      chan_b_fir_tap9_coeff_reg <= fcb_pkg::TAP_RST;
    end else if (wr9) begin
      chan_b_fir_tap9_coeff_reg <= reg_req.wdata;
    end
  end

  logic [fcb_pkg::COEFF_W-1:0] chan_b_tap6_value;
  logic [fcb_pkg::COEFF_W-1:0] chan_b_tap7_value;
  logic [fcb_pkg::COEFF_W-1:0] chan_b_tap8_value;
  logic [fcb_pkg::COEFF_W-1:0] chan_b_tap9_value;

  assign chan_b_tap6_value = chan_b_fir_tap6_coeff_reg[fcb_pkg::COEFF_MSB:fcb_pkg::COEFF_LSB];
  assign chan_b_tap7_value = chan_b_fir_tap7_coeff_reg[fcb_pkg::COEFF_MSB:fcb_pkg::COEFF_LSB];
  assign chan_b_tap8_value = chan_b_fir_tap8_coeff_reg[fcb_pkg::COEFF_MSB:fcb_pkg::COEFF_LSB];
  assign chan_b_tap9_value = chan_b_fir_tap9_coeff_reg[fcb_pkg::COEFF_MSB:fcb_pkg::COEFF_LSB];

  // Read path; tap nine hides its coefficient MSB on readback only
  logic [fcb_pkg::DATA_W-1:0] tap9_view;
  logic [fcb_pkg::DATA_W-1:0] rd_sel;
  logic [fcb_pkg::DATA_W-1:0] reg_rdata_next;
  logic [fcb_pkg::DATA_W-1:0] reg_rdata_reg;

  assign tap9_view = {chan_b_fir_tap9_coeff_reg[fcb_pkg::RESV_MSB:fcb_pkg::RESV_LSB],
                      1'b0,
                      chan_b_fir_tap9_coeff_reg[fcb_pkg::COEFF_MSB-1:0]};
  assign rd_sel = hit6 ? chan_b_fir_tap6_coeff_reg :
                  hit7 ? chan_b_fir_tap7_coeff_reg :
                  hit8 ? chan_b_fir_tap8_coeff_reg :
                  hit9 ? tap9_view : fcb_pkg::RD_UNMAP;
  // Data only in the cycle after the strobe, zero otherwise
  assign reg_rdata_next = reg_req.rd ? rd_sel : fcb_pkg::RD_UNMAP;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_reg <= fcb_pkg::RD_UNMAP;
    end else begin
      reg_rdata_reg <= reg_rdata_next;
    end
  end

  assign reg_rdata = reg_rdata_reg;

  // Coefficient set, sign-extended to centre-tap width
  logic signed [fcb_pkg::CENTER_W-1:0] coef_w [fcb_pkg::NUM_TAPS];

  assign coef_w[0] = {{EXT_W{chan_b_tap1_value[fcb_pkg::COEFF_MSB]}}, chan_b_tap1_value};
  assign coef_w[1] = {{EXT_W{chan_b_tap2_value[fcb_pkg::COEFF_MSB]}}, chan_b_tap2_value};
  assign coef_w[2] = {{EXT_W{chan_b_tap3_value[fcb_pkg::COEFF_MSB]}}, chan_b_tap3_value};
  assign coef_w[3] = {{EXT_W{chan_b_tap4_value[fcb_pkg::COEFF_MSB]}}, chan_b_tap4_value};
  assign coef_w[fcb_pkg::CTR_IDX] = chan_b_center_tap_value;
  assign coef_w[5] = {{EXT_W{chan_b_tap6_value[fcb_pkg::COEFF_MSB]}}, chan_b_tap6_value};
  assign coef_w[6] = {{EXT_W{chan_b_tap7_value[fcb_pkg::COEFF_MSB]}}, chan_b_tap7_value};
  assign coef_w[7] = {{EXT_W{chan_b_tap8_value[fcb_pkg::COEFF_MSB]}}, chan_b_tap8_value};
  // Full written value, MSB included, drives the filter
  assign coef_w[8] = {{EXT_W{chan_b_tap9_value[fcb_pkg::COEFF_MSB]}}, chan_b_tap9_value};

  // Sample history: tap one sees the newest sample
  logic signed [SAMPLE_W-1:0] hist_reg [fcb_pkg::NUM_TAPS-1];
  logic signed [SAMPLE_W-1:0] dline_w  [fcb_pkg::NUM_TAPS];
  logic signed [PROD_W-1:0]   prod_w   [fcb_pkg::NUM_TAPS];
  logic                       take;

  assign take       = samp_valid & dual_mode;
  assign dline_w[0] = samp_in;

  genvar gi;
  generate
    for (gi = 1; gi < fcb_pkg::NUM_TAPS; gi++) begin : g_dline
      assign dline_w[gi] = hist_reg[gi-1];
    end
    for (gi = 0; gi < fcb_pkg::NUM_TAPS; gi++) begin : g_prod
      assign prod_w[gi] = dline_w[gi] * coef_w[gi];
    end
  endgenerate

  // History only advances in dual mode, so a mode change keeps old context
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < fcb_pkg::NUM_TAPS - 1; i++) begin
        hist_reg[i] <= '0;
      end
    end else if (take) begin
      for (int i = 0; i < fcb_pkg::NUM_TAPS - 1; i++) begin
        hist_reg[i] <= dline_w[i];
      end
    end
  end

  // Four guard bits cover nine full-scale products
  logic signed [ACC_W-1:0] acc_w;

  always_comb begin
    acc_w = '0;
    for (int i = 0; i < fcb_pkg::NUM_TAPS; i++) begin
      acc_w = acc_w + ACC_W'(prod_w[i]);
    end
  end

  logic signed [ACC_W-1:0] filt_out_reg;
  logic                    filt_valid_reg;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      filt_out_reg   <= '0;
      filt_valid_reg <= 1'b0;
    end else begin
      filt_valid_reg <= take;
      if (take) begin
        filt_out_reg <= acc_w;
      end
    end
  end

  assign filt_out   = filt_out_reg;
  assign filt_valid = filt_valid_reg;

  // Checks
  property p_resv_write;
    @(posedge clk_sys) disable iff (!rst_n)
      wr7 |=> chan_b_fir_tap7_coeff_reg[fcb_pkg::RESV_MSB:fcb_pkg::RESV_LSB]
              == $past(reg_req.wdata[fcb_pkg::RESV_MSB:fcb_pkg::RESV_LSB]);
  endproperty
  a_resv_write: assert property (p_resv_write)
    else $error("reserved bits not stored");

  property p_unmapped_zero;
    @(posedge clk_sys) disable iff (!rst_n)
      (reg_req.rd && !hit_any) |=> reg_rdata == fcb_pkg::RD_UNMAP;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero)
    else $error("unmapped read not zero");

  property p_reset_zero;
    @(posedge clk_sys)
      $rose(rst_n) |-> (chan_b_fir_tap6_coeff_reg == fcb_pkg::TAP_RST)
                    && (chan_b_fir_tap9_coeff_reg == fcb_pkg::TAP_RST);
  endproperty
  a_reset_zero: assert property (p_reset_zero)
    else $error("coefficients not zero after reset");

  property p_tap6_read;
    @(posedge clk_sys) disable iff (!rst_n)
      (reg_req.rd && hit6) |=> reg_rdata == $past(chan_b_fir_tap6_coeff_reg);
  endproperty
  a_tap6_read: assert property (p_tap6_read)
    else $error("tap six readback wrong");

  property p_tap7_wr_rd;
    @(posedge clk_sys) disable iff (!rst_n)
      wr7 ##1 (reg_req.rd && hit7 && !reg_req.wr) |=> reg_rdata == $past(reg_req.wdata, 2);
  endproperty
  a_tap7_wr_rd: assert property (p_tap7_wr_rd)
    else $error("tap seven write then read mismatch");

  property p_tap8_read;
    @(posedge clk_sys) disable iff (!rst_n)
      (reg_req.rd && hit8) |=> reg_rdata == $past(chan_b_fir_tap8_coeff_reg);
  endproperty
  a_tap8_read: assert property (p_tap8_read)
    else $error("tap eight readback wrong");

  property p_tap9_filter_msb;
    @(posedge clk_sys) disable iff (!rst_n)
      wr9 |=> coef_w[8][fcb_pkg::CENTER_W-1] == $past(reg_req.wdata[fcb_pkg::COEFF_MSB]);
  endproperty
  a_tap9_filter_msb: assert property (p_tap9_filter_msb)
    else $error("tap nine sign not used by filter");

  property p_tap9_msb_hidden;
    @(posedge clk_sys) disable iff (!rst_n)
      (reg_req.rd && hit9) |=> !reg_rdata[fcb_pkg::COEFF_MSB]
        && reg_rdata[fcb_pkg::COEFF_MSB-1:0] == $past(chan_b_tap9_value[fcb_pkg::COEFF_MSB-1:0]);
  endproperty
  a_tap9_msb_hidden: assert property (p_tap9_msb_hidden)
    else $error("tap nine readback MSB not zero");

  property p_center_full;
    @(posedge clk_sys) disable iff (!rst_n)
      coef_w[fcb_pkg::CTR_IDX] == $signed(chan_b_center_tap_value);
  endproperty
  a_center_full: assert property (p_center_full)
    else $error("centre tap truncated");

  property p_filter_out;
    @(posedge clk_sys) disable iff (!rst_n)
      take |=> filt_valid && filt_out == $past(acc_w);
  endproperty
  a_filter_out: assert property (p_filter_out)
    else $error("filter output wrong or late");

  property p_no_spurious;
    @(posedge clk_sys) disable iff (!rst_n)
      !take |=> !filt_valid && $stable(filt_out);
  endproperty
  a_no_spurious: assert property (p_no_spurious)
    else $error("output moved without a sample");

endmodule : fcb_upper_taps

// ==== tb/tb_fcb_upper_taps.sv ====
// Self-checking bench for the channel B upper-tap coefficient bank and filter.
// Assumes the register port and sample stream of fcb_upper_taps at default width.
`timescale 1ns/100ps

module tb_fcb_upper_taps;
  localparam int SW    = 12;
  localparam int OUT_W = SW + fcb_pkg::CENTER_W + fcb_pkg::SUM_GROW;

  logic                         clk_sys;
  logic                         nrst;
  fcb_pkg::fcb_reg_req_t        reg_req;
  logic [fcb_pkg::DATA_W-1:0]   reg_rdata;
  logic                         dual_mode;
  logic                         samp_valid;
  logic signed [SW-1:0]         samp_in;
  logic [fcb_pkg::COEFF_W-1:0]  tap_in [4];
  logic [fcb_pkg::CENTER_W-1:0] center;
  logic signed [OUT_W-1:0]      filt_out;
  logic                         filt_valid;
  int                           n_mismatch;
  int                           cmp_count;
  int                           cyc;
  logic [15:0]                  shadow [4];
  logic [11:0]                  ofs [4];
  longint                       hist [9];
  logic [OUT_W-1:0]             last_exp;
  int unsigned                  seed_dummy;

  fcb_upper_taps #(.SAMPLE_W(SW)) u_fcb_upper_taps (
    .clk_sys                 (clk_sys),
    .nrst                    (nrst),
    .reg_req                 (reg_req),
    .reg_rdata               (reg_rdata),
    .dual_mode               (dual_mode),
    .samp_valid              (samp_valid),
    .samp_in                 (samp_in),
    .chan_b_tap1_value       (tap_in[0]),
    .chan_b_tap2_value       (tap_in[1]),
    .chan_b_tap3_value       (tap_in[2]),
    .chan_b_tap4_value       (tap_in[3]),
    .chan_b_center_tap_value (center),
    .filt_out                (filt_out),
    .filt_valid              (filt_valid)
  );

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  task automatic summarize();
    $display("mismatches=%0d comparisons=%0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : summarize

  // Ceiling is more than thirty times the length of the whole sequence
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_mismatch = n_mismatch + 1;
      summarize();
    end
  end

  task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t rdata got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp16

  task automatic cmpw(input logic [OUT_W-1:0] got, input logic [OUT_W-1:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t filt got=%h exp=%h", $time, got, exp);
    end
  endtask : cmpw

  task automatic cmp1(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t flag got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp1

  function automatic longint sx12(input logic [11:0] v);
    return longint'(signed'(v));
  endfunction : sx12

  // Tap nine keeps its full written value in the sum
  function automatic longint fir_exp();
    longint s;
    s = 0;
    for (int k = 0; k < 9; k++) begin
      if (k < 4) s += sx12(tap_in[k]) * hist[k];
      else if (k == 4) s += longint'(signed'(center)) * hist[k];
      else s += sx12(shadow[k-5][11:0]) * hist[k];
    end
    return s;
  endfunction : fir_exp

  // Leaves wr high; every write sequence here ends in a read, which lowers it
  task automatic reg_wr(input logic [11:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_req.wr    <= 1'b1;
    reg_req.rd    <= 1'b0;
    reg_req.addr  <= a;
    reg_req.wdata <= d;
  endtask : reg_wr

  task automatic reg_rd(input logic [11:0] a, input logic [15:0] exp);
    @(posedge clk_sys);
    reg_req.wr   <= 1'b0;
    reg_req.rd   <= 1'b1;
    reg_req.addr <= a;
    @(posedge clk_sys);
    reg_req.rd <= 1'b0;
    #1;
    cmp16(reg_rdata, exp);
  endtask : reg_rd

  // Back-to-back samples; result of each is checked just after the edge that takes it, one edge after it is driven
  task automatic run_stream(input int n, input logic dm);
    logic signed [SW-1:0] x;
    for (int i = 0; i <= n; i++) begin
      @(posedge clk_sys);
      x = SW'($urandom());
      samp_valid <= (i < n);
      samp_in    <= x;
      dual_mode  <= dm;
      #1;
      if (i > 0) begin
        cmp1(filt_valid, dm);
        cmpw(filt_out, last_exp);
      end
      if (i < n && dm) begin
        for (int k = 8; k > 0; k--) hist[k] = hist[k-1];
        hist[0]  = longint'(x);
        last_exp = OUT_W'(fir_exp());
      end
    end
  endtask : run_stream

  initial begin
    nrst       = 1'b0;
    reg_req    = '0;
    dual_mode  = 1'b0;
    samp_valid = 1'b0;
    samp_in    = '0;
    center     = '0;
    last_exp   = '0;
    cyc        = 0;
    n_mismatch = 0;
    cmp_count  = 0;
    ofs = '{fcb_pkg::TAP6_OFS, fcb_pkg::TAP7_OFS, fcb_pkg::TAP8_OFS, fcb_pkg::TAP9_OFS};
    foreach (tap_in[i]) tap_in[i] = '0;
    foreach (hist[i]) hist[i] = 0;
    seed_dummy = $urandom(24);
    repeat (3) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    foreach (ofs[i]) reg_rd(ofs[i], 16'h0000);
    // Extreme coefficients first, then random ones
    for (int r = 0; r < 3; r++) begin
      foreach (ofs[i]) begin
        shadow[i] = (r == 0) ? 16'hF800 : (r == 1) ? 16'h07FF : 16'($urandom());
        reg_wr(ofs[i], shadow[i]);
        reg_rd(ofs[i], (i == 3) ? (shadow[i] & 16'hF7FF) : shadow[i]);
      end
      @(posedge clk_sys);
      foreach (tap_in[i]) tap_in[i] <= 12'($urandom());
      center <= 18'($urandom());
      run_stream(12, 1'b1);
    end
    reg_wr(12'h454, 16'hFFFF);
    reg_rd(12'h454, 16'h0000);
    reg_rd(ofs[0], shadow[0]);
    @(posedge clk_sys);
    #1;
    cmp16(reg_rdata, 16'h0000);
    run_stream(5, 1'b0);
    run_stream(6, 1'b1);
    // Mid-run reset must clear written coefficients and the sample history
    @(posedge clk_sys);
    nrst <= 1'b0;
    repeat (3) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    #1;
    cmp1(filt_valid, 1'b0);
    cmpw(filt_out, '0);
    foreach (ofs[i]) reg_rd(ofs[i], 16'h0000);
    foreach (shadow[i]) shadow[i] = '0;
    foreach (hist[i]) hist[i] = 0;
    run_stream(10, 1'b1);
    summarize();
  end
endmodule : tb_fcb_upper_taps
